// [smb_ctrl.v]
// Two-wire bus configuration, control and byte-level sequencing engine
`timescale 1ns/1ps
`default_nettype none
`include "smb_defines.vh"

module smb_ctrl (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register port
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Bit-rate source overflow pulses
	input wire t0_ovf,
	input wire t1_ovf,
	input wire t2h_ovf,
	input wire t2l_ovf,
	// Timer 3 low-watch control
	input wire t3_split,
	output wire t3_reload_hi,
	output wire t3_reload_lo,
	// Slave address compare result
	input wire addr_match,
	// Bus pins, open drain
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe_n,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n
);

// ----------------------------------------
// Engine states
// ----------------------------------------
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_START = 6'h02;
localparam [5:0] ST_LOW = 6'h04;
localparam [5:0] ST_HIGH = 6'h08;
localparam [5:0] ST_STOP = 6'h10;
localparam [5:0] ST_RS = 6'h20;

// ----------------------------------------
// State
// ----------------------------------------
reg en_r;
reg quiet_r;
reg busy_r;
reg ext_r;
reg loww_r;
reg idle_r;
reg [1:0] src_r;
reg master_r;
reg txdir_r;
reg begin_r;
reg end_r;
reg ackreq_r;
reg arb_r;
reg ack_r;
reg si_r;
reg auto_r;
reg [7:0] byte_r;
reg data_wr_r;
reg ack_wr_r;
reg addr_ph_r;
reg ignore_r;
reg stop2_r;
reg [5:0] state_r;
reg [3:0] bit_r;
reg [4:0] hs_r;
reg [3:0] free_r;
reg tick_seen_r;
reg pull_scl_r;
reg pull_sda_r;
reg [2:0] scl_sy_r;
reg [2:0] sda_sy_r;
reg scl_r;
reg sda_r;
reg tick;

// ----------------------------------------
// Line filtering and condition detection
// ----------------------------------------
// A change counts only once the second and third stages agree
wire scl_nxt = (scl_sy_r[1] == scl_sy_r[2]) ? scl_sy_r[2] : scl_r;
wire sda_nxt = (sda_sy_r[1] == sda_sy_r[2]) ? sda_sy_r[2] : sda_r;
wire scl_rise = scl_nxt & ~scl_r;
wire scl_fall = ~scl_nxt & scl_r;
wire start_det = scl_r & scl_nxt & sda_r & ~sda_nxt;
wire stop_det = scl_r & scl_nxt & ~sda_r & sda_nxt;

// Synchronisers; stage 0 feeds stage 1 only
always @(posedge clk) begin
	if (rst) begin
		scl_sy_r <= 3'h7;
		sda_sy_r <= 3'h7;
		scl_r <= 1'b1;
		sda_r <= 1'b1;
	end else begin
		scl_sy_r <= {scl_sy_r[1:0], scl_in};
		sda_sy_r <= {sda_sy_r[1:0], sda_in};
		scl_r <= scl_nxt;
		sda_r <= sda_nxt;
	end
end

// ----------------------------------------
// Bit-rate source and timing figures
// ----------------------------------------
// Overflow mux, one pulse advances timing one period
always @* begin
	case (src_r)
	`SMB_SRC_T0: tick = t0_ovf;
	`SMB_SRC_T1: tick = t1_ovf;
	`SMB_SRC_T2H: tick = t2h_ovf;
	default: tick = t2l_ovf;
	endcase
end

// Longer hold and setup once extension is on
wire [4:0] hold_n = ext_r ? `SMB_HOLD_EXT : `SMB_HOLD_STD;
wire [4:0] setup_n = ext_r ? `SMB_SETUP_EXT : `SMB_SETUP_STD;
wire [4:0] go_n = hold_n + setup_n;

// Outgoing ACK: NACK unless software wrote it or hardware mode is on
wire ack_out = (auto_r & addr_ph_r) ? (addr_match & ack_r)
	: ((auto_r | ack_wr_r) & ack_r);

// Sample point: slave on SCL rise, master at end of high phase
wire smp = en_r & ~si_r & ((state_r == ST_LOW) & ~master_r & scl_rise
	| (state_r == ST_HIGH) & master_r & scl_r & tick_seen_r);
wire arb_ev = smp & (bit_r < 4'h8) & txdir_r & ~pull_sda_r & ~sda_r;

// ----------------------------------------
// Pins and Timer 3 control
// ----------------------------------------
assign scl_out = 1'b0;
assign sda_out = 1'b0;
assign scl_oe_n = ~pull_scl_r;
assign sda_oe_n = ~pull_sda_r;
// Both timer bytes held in reload while the clock line is high; high byte only in split mode
assign t3_reload_hi = loww_r & scl_r;
assign t3_reload_lo = loww_r & scl_r & ~t3_split;

// ----------------------------------------
// Register read port
// ----------------------------------------
// Data valid only in the cycle after the read strobe
always @(posedge clk) begin
	if (rst) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		case (reg_addr)
		`SMB_OFF_CFG: reg_rdata <= {en_r, quiet_r, busy_r, ext_r, loww_r, idle_r, src_r};
		`SMB_OFF_CTRL: reg_rdata <= {master_r, txdir_r, begin_r, end_r,
			ackreq_r, arb_r, ack_r, si_r};
		`SMB_OFF_MASK: reg_rdata <= {7'h00, auto_r};
		default: reg_rdata <= byte_r;
		endcase
	end else begin
		reg_rdata <= 8'h00;
	end
end

// ----------------------------------------
// Registers and bus engine
// ----------------------------------------
// One process owns every flag so hardware sets land after software
// writes in the same cycle and therefore win
always @(posedge clk) begin
	if (rst) begin
		{en_r, quiet_r, busy_r, ext_r, loww_r, idle_r, src_r} <= `SMB_CFG_RST;
		{master_r, txdir_r, begin_r, end_r, ackreq_r, arb_r, ack_r, si_r} <= `SMB_CTRL_RST;
		auto_r <= 1'b0;
		byte_r <= `SMB_BYTE_RST;
		data_wr_r <= 1'b0;
		ack_wr_r <= 1'b0;
		addr_ph_r <= 1'b0;
		ignore_r <= 1'b0;
		stop2_r <= 1'b0;
		state_r <= ST_IDLE;
		bit_r <= 4'h0;
		hs_r <= 5'h00;
		free_r <= 4'h0;
		tick_seen_r <= 1'b0;
		pull_scl_r <= 1'b0;
		pull_sda_r <= 1'b0;
	end else begin
		// Software writes
		if (reg_wr) begin
			case (reg_addr)
			`SMB_OFF_CFG: begin
				en_r <= reg_wdata[`SMB_CFG_EN];
				quiet_r <= reg_wdata[`SMB_CFG_QUIET];
				ext_r <= reg_wdata[`SMB_CFG_HOLD];
				loww_r <= reg_wdata[`SMB_CFG_LOWW];
				idle_r <= reg_wdata[`SMB_CFG_IDLE];
				src_r <= reg_wdata[`SMB_CFG_SRC_HI:`SMB_CFG_SRC_LO];
			end
			`SMB_OFF_CTRL: begin
				begin_r <= reg_wdata[`SMB_CTL_BEGIN];
				end_r <= reg_wdata[`SMB_CTL_END];
				ack_r <= reg_wdata[`SMB_CTL_ACK];
				ack_wr_r <= 1'b1;
				si_r <= reg_wdata[`SMB_CTL_SI];
				if (!reg_wdata[`SMB_CTL_SI]) begin
					arb_r <= 1'b0;
					ackreq_r <= 1'b0;
				end
			end
			`SMB_OFF_MASK: auto_r <= reg_wdata[`SMB_MASK_AUTO];
			default: begin
				byte_r <= reg_wdata;
				data_wr_r <= 1'b1;
			end
			endcase
		end
		// Overflow pulses are remembered until a phase consumes them
		if (tick) begin
			tick_seen_r <= 1'b1;
		end
		// Idle lines counted in source periods
		// Lines held by this block are not an idle bus
		if (scl_r && sda_r && !pull_scl_r && !pull_sda_r) begin
			if (tick && free_r <= `SMB_FREE_PERIODS) begin
				free_r <= free_r + 4'h1;
			end
		end else begin
			free_r <= 4'h0;
		end
		if (!en_r) begin
			// Disabled: lines released, engine parked
			state_r <= ST_IDLE;
			master_r <= 1'b0;
			busy_r <= 1'b0;
			pull_scl_r <= 1'b0;
			pull_sda_r <= 1'b0;
		end else begin
			// Monitoring runs whenever enabled
			if (start_det) begin
				busy_r <= 1'b1;
			end
			if (stop_det || (idle_r && free_r > `SMB_FREE_PERIODS)) begin
				busy_r <= 1'b0;
			end
			case (state_r)
			ST_IDLE: begin
				pull_scl_r <= 1'b0;
				pull_sda_r <= 1'b0;
				// Master request waits for a free bus
				if (begin_r && !busy_r && !si_r) begin
					state_r <= ST_START;
					tick_seen_r <= 1'b0;
				end
			end
			ST_START: begin
				pull_sda_r <= 1'b1;
				if (tick_seen_r) begin
					// START out; begin flag stays set
					pull_scl_r <= 1'b1;
					master_r <= 1'b1;
					busy_r <= 1'b1;
					si_r <= 1'b1;
					bit_r <= 4'h0;
					hs_r <= 5'h00;
					state_r <= ST_LOW;
				end
			end
			ST_LOW: begin
				if (si_r) begin
					// Stalled: clock held, ACK value shown at once
					pull_scl_r <= 1'b1;
					hs_r <= 5'h00;
					tick_seen_r <= 1'b0;
					if (bit_r == 4'h8 && !txdir_r) begin
						pull_sda_r <= ack_out;
					end
				end else if (master_r && bit_r == 4'h0 && hs_r == 5'h00 && end_r) begin
					state_r <= ST_STOP;
					stop2_r <= 1'b0;
				end else if (master_r && bit_r == 4'h0 && hs_r == 5'h00 && begin_r) begin
					state_r <= ST_RS;
				end else begin
					if (master_r && bit_r == 4'h0 && hs_r == 5'h00) begin
						// Direction set by whether data was loaded
						txdir_r <= data_wr_r;
						data_wr_r <= 1'b0;
					end
					if (hs_r != 5'h1F) begin
						hs_r <= hs_r + 5'h01;
					end
					// SDA changes only after the hold time
					if (hs_r == hold_n) begin
						if (bit_r < 4'h8) begin
							pull_sda_r <= txdir_r & ~byte_r[7];
						end else begin
							pull_sda_r <= ~txdir_r & ack_out;
						end
					end
					if (master_r) begin
						// Release only after setup and a source period
						if (hs_r >= go_n && tick_seen_r) begin
							pull_scl_r <= 1'b0;
							tick_seen_r <= 1'b0;
							state_r <= ST_HIGH;
						end
					end else begin
						if (hs_r > hold_n) begin
							pull_scl_r <= 1'b0;
						end
						if (scl_rise) begin
							state_r <= ST_HIGH;
						end
					end
				end
			end
			ST_HIGH: begin
				if (master_r) begin
					// Slow slaves may stretch; period counts from the high level
					if (!scl_r) begin
						tick_seen_r <= 1'b0;
					end else if (tick_seen_r) begin
						pull_scl_r <= 1'b1;
						tick_seen_r <= 1'b0;
						hs_r <= 5'h00;
						state_r <= ST_LOW;
					end
				end else if (scl_fall) begin
					hs_r <= 5'h00;
					state_r <= ST_LOW;
				end
			end
			ST_STOP: begin
				// SDA low, release SCL, then release SDA high
				pull_sda_r <= ~stop2_r | ~scl_r;
				if (tick_seen_r) begin
					tick_seen_r <= 1'b0;
					if (!stop2_r) begin
						// SCL released only once SDA is already held low
						if (pull_sda_r) begin
							pull_scl_r <= 1'b0;
							stop2_r <= scl_r;
						end
					end else begin
						pull_sda_r <= 1'b0;
						end_r <= 1'b0;
						master_r <= 1'b0;
						state_r <= begin_r ? ST_START : ST_IDLE;
					end
				end
			end
			ST_RS: begin
				// Repeated START: both lines released first
				pull_sda_r <= 1'b0;
				pull_scl_r <= 1'b0;
				if (tick_seen_r && scl_r) begin
					tick_seen_r <= 1'b0;
					state_r <= ST_START;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
			// Sampling of one bit
			if (smp) begin
				bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
				if (master_r) begin
					pull_scl_r <= 1'b1;
					tick_seen_r <= 1'b0;
					hs_r <= 5'h00;
					state_r <= ST_LOW;
				end else begin
					state_r <= ST_HIGH;
				end
				if (bit_r < 4'h8) begin
					byte_r <= {byte_r[6:0], sda_r};
				end
				if (bit_r == 4'h7 && !txdir_r) begin
					if (addr_ph_r) begin
						begin_r <= 1'b1;
					end
					if (!auto_r) begin
						si_r <= 1'b1;
						ackreq_r <= 1'b1;
						ack_wr_r <= 1'b0;
					end
				end
				if (bit_r == 4'h8) begin
					if (txdir_r) begin
						ack_r <= ~sda_r;
					end
					if (addr_ph_r) begin
						addr_ph_r <= 1'b0;
						if (!ack_out) begin
							// Not ours: silent until next START
							ignore_r <= 1'b1;
							pull_sda_r <= 1'b0;
							pull_scl_r <= 1'b0;
							state_r <= ST_IDLE;
						end else begin
							si_r <= 1'b1;
							txdir_r <= byte_r[0];
						end
					end else begin
						si_r <= 1'b1;
					end
				end
			end
			// Lost arbitration drops to slave and releases SDA; SCL is released for one cycle, then held again by the pending flag
			if (arb_ev) begin
				arb_r <= 1'b1;
				si_r <= 1'b1;
				master_r <= 1'b0;
				txdir_r <= 1'b0;
				pull_sda_r <= 1'b0;
				pull_scl_r <= 1'b0;
				state_r <= ST_IDLE;
			end
			// Slave START capture, inhibited while target_quiet is set
			if (start_det && !master_r && state_r != ST_START) begin
				ignore_r <= 1'b0;
				if (!quiet_r) begin
					state_r <= ST_HIGH;
					bit_r <= 4'h0;
					addr_ph_r <= 1'b1;
					txdir_r <= 1'b0;
					pull_sda_r <= 1'b0;
				end
			end
			// STOP seen while addressed ends the slave transfer
			if (stop_det && !master_r && state_r != ST_IDLE && state_r != ST_START
				&& !ignore_r) begin
				end_r <= 1'b1;
				si_r <= 1'b1;
				pull_sda_r <= 1'b0;
				pull_scl_r <= 1'b0;
				state_r <= ST_IDLE;
			end
			// Pending flag stalls the clock in every state, idle included
			if (si_r) begin
				pull_scl_r <= 1'b1;
			end
		end
	end
end

endmodule // smb_ctrl
`default_nettype wire

// [smb_defines.vh]
// Register offsets, field positions, reset values and timing counts of the bus controller
`ifndef SMB_DEFINES_VH
`define SMB_DEFINES_VH

// ----------------------------------------
// Register offsets (register port address)
// ----------------------------------------
`define SMB_OFF_CFG 2'h0
`define SMB_OFF_CTRL 2'h1
`define SMB_OFF_MASK 2'h2
`define SMB_OFF_BYTE 2'h3

// ----------------------------------------
// cfg_reg field positions
// ----------------------------------------
`define SMB_CFG_EN 7
`define SMB_CFG_QUIET 6
`define SMB_CFG_BUSY 5
`define SMB_CFG_HOLD 4
`define SMB_CFG_LOWW 3
`define SMB_CFG_IDLE 2
`define SMB_CFG_SRC_HI 1
`define SMB_CFG_SRC_LO 0

// ----------------------------------------
// ctrl_reg field positions
// ----------------------------------------
`define SMB_CTL_MASTER 7
`define SMB_CTL_TXDIR 6
`define SMB_CTL_BEGIN 5
`define SMB_CTL_END 4
`define SMB_CTL_ACKREQ 3
`define SMB_CTL_ARB 2
`define SMB_CTL_ACK 1
`define SMB_CTL_SI 0

// addr_mask_reg field position
`define SMB_MASK_AUTO 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMB_CFG_RST 8'h00
`define SMB_CTRL_RST 8'h00
`define SMB_MASK_RST 8'h00
`define SMB_BYTE_RST 8'h00

// ----------------------------------------
// Bit-rate source select codes
// ----------------------------------------
`define SMB_SRC_T0 2'h0
`define SMB_SRC_T1 2'h1
`define SMB_SRC_T2H 2'h2
`define SMB_SRC_T2L 2'h3

// ----------------------------------------
// Timing counts (system clocks / source periods)
// ----------------------------------------
`define SMB_FREE_PERIODS 4'hA
`define SMB_HOLD_STD 5'h03
`define SMB_HOLD_EXT 5'h0C
`define SMB_SETUP_STD 5'h04
`define SMB_SETUP_EXT 5'h0B

`endif

// [smb_props.sv]
// Concurrent checks on the bus controller ports
`timescale 1ns/1ps
`default_nettype none
module smb_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Timer and pins
	input wire logic t3_split,
	input wire logic t3_reload_hi,
	input wire logic t3_reload_lo,
	input wire logic scl_in,
	input wire logic scl_oe_n,
	input wire logic sda_oe_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Write then read of one register, back to back
	sequence wr_rd(a);
		reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
	endsequence
	AST_SRC_SEL: assert property (wr_rd(2'h0) |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
		else $error("source select readback wrong");
	AST_LONG_HOLD: assert property (wr_rd(2'h0) |=> reg_rdata[4] == $past(reg_wdata[4], 2))
		else $error("long hold readback wrong");
	AST_FORCE_SI: assert property (reg_wr && reg_addr == 2'h1 && reg_wdata[0]
		##1 reg_rd && reg_addr == 2'h1 |=> reg_rdata[0])
		else $error("forced interrupt flag missing");
	AST_ARB_CLR: assert property (reg_wr && reg_addr == 2'h1 && !reg_wdata[0]
		##1 reg_rd && reg_addr == 2'h1 |=> !reg_rdata[2])
		else $error("arbitration flag not cleared");
	// Software may release the stall in the very next cycles
	AST_SI_STALL: assert property (reg_rd && reg_addr == 2'h1 ##1 reg_rdata[0]
		|-> ##[0:2] !scl_oe_n)
		else $error("clock not held while flag set");
	AST_T3_SPLIT: assert property (t3_reload_lo |-> t3_reload_hi && !t3_split)
		else $error("low byte reload in split mode");
	AST_T3_LOW: assert property ((!scl_in) [*6] |-> !t3_reload_hi)
		else $error("timer reload while clock low");
	AST_HOLD: assert property ($fell(scl_oe_n) |-> $stable(sda_oe_n) [*2])
		else $error("data hold too short");
	AST_SETUP: assert property ($rose(scl_oe_n) |-> $stable(sda_oe_n))
		else $error("data changed at clock release");
	AST_START: assert property ($fell(sda_oe_n) && scl_oe_n && scl_in
		|-> ##[1:300] !scl_oe_n)
		else $error("no clock after start");
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	// Main scenarios reached
	cover property (wr_rd(2'h0));
	cover property ($fell(sda_oe_n) && scl_oe_n);
	cover property (t3_reload_hi && !t3_reload_lo);
endmodule // smb_props
bind smb_ctrl smb_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.t3_split(t3_split), .t3_reload_hi(t3_reload_hi), .t3_reload_lo(t3_reload_lo),
	.scl_in(scl_in), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));
`default_nettype wire

// [smb_peer.sv]
// Behavioural slave on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module smb_peer (
	// Clock
	input wire logic clk,
	// Bus lines
	input wire logic scl,
	input wire logic sda,
	output logic sda_pull,
	// Last byte seen
	output logic [7:0] rx_byte
);
	logic scl_d = 1'b1;
	logic sda_d = 1'b1;
	int cnt = 0;
	initial sda_pull = 1'b0;
	initial rx_byte = 8'h00;
	// Frames counted from each START; released lines float to the pull-up
	always @(posedge clk) begin
		scl_d <= scl;
		sda_d <= sda;
		if (scl && scl_d && sda_d && !sda) begin
			cnt <= 0;
		end else if (scl && !scl_d) begin
			if (cnt < 8)
				rx_byte <= {rx_byte[6:0], sda}; // MSB first
			cnt <= cnt + 1;
		end else if (!scl && scl_d) begin
			if (cnt == 8)
				sda_pull <= 1'b1; // Acknowledge each byte
			if (cnt == 9) begin
				sda_pull <= 1'b0;
				cnt <= 0;
			end
		end
	end
endmodule // smb_peer
`default_nettype wire

// [tb.sv]
// Self-checking bench of the bus controller
`timescale 1ns/1ps
`default_nettype none
`include "smb_defines.vh"
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic t0_ovf = 1'b0, t1_ovf = 1'b0, t2h_ovf = 1'b0, t2l_ovf = 1'b0;
	logic t3_split = 1'b0;
	logic addr_match = 1'b0;
	wire [7:0] reg_rdata;
	wire [7:0] rx_byte;
	wire t3_reload_hi, t3_reload_lo, scl_oe_n, sda_oe_n, pull;
	// Open-drain wires with pull-ups; the peer never stretches the clock
	wire scl = scl_oe_n;
	wire sda = sda_oe_n & ~pull;
	int miscompares = 0;
	int cmp_count = 0;
	int tick = 0;
	logic [31:0] seed = 32'hBA21;
	logic [7:0] cfg_m, d, got;
	// Reference model: bytes the far side must receive, in order
	logic [7:0] exp_q[$];
	always #5 clk = ~clk;
	// Overflow pulses at four different rates, every 16, 12, 20 and 8 clocks
	always @(posedge clk) begin
		tick <= tick + 1;
		t0_ovf <= (tick % 16) == 0;
		t1_ovf <= (tick % 12) == 0;
		t2h_ovf <= (tick % 20) == 0;
		t2l_ovf <= (tick % 8) == 0;
	end
	smb_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_ovf(t0_ovf),
		.t1_ovf(t1_ovf), .t2h_ovf(t2h_ovf), .t2l_ovf(t2l_ovf), .t3_split(t3_split),
		.t3_reload_hi(t3_reload_hi), .t3_reload_lo(t3_reload_lo), .addr_match(addr_match),
		.scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
		.sda_oe_n(sda_oe_n));
	smb_peer peer (.clk(clk), .scl(scl), .sda(sda), .sda_pull(pull), .rx_byte(rx_byte));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (e !== g) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Strobes stay up until the next access or idle, so accesses may run back to back
	task automatic op(input logic w, input logic [1:0] a, input logic [7:0] v);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		#1 got = reg_rdata;
	endtask
	task automatic cyc(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk);
		// Step off the edge so outputs are settled when looked at
		#1;
	endtask
	// Bounded poll of one register bit
	task automatic wait_bit(input logic [1:0] a, input int b, input logic val);
		int i;
		op(1'b0, a, 8'h00);
		for (i = 0; i < 400 && got[b] !== val; i++)
			op(1'b0, a, 8'h00);
		chk("poll", {7'h00, val}, {7'h00, got[b]});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a < 4; a++) begin
			op(1'b0, a[1:0], 8'h00);
			chk("reset value", 8'h00, got);
		end
		// Every source code; busy bit is read-only
		for (int s = 0; s < 4; s++) begin
			seed = lfsr(seed);
			cfg_m = 8'h8C | s[7:0] | {3'h0, seed[4], 4'h0};
			op(1'b1, 2'h0, cfg_m | 8'h20);
			op(1'b0, 2'h0, 8'h00);
			chk("cfg", cfg_m, got);
		end
		cyc(8);
		chk("t3 reload", 8'h03, {6'h00, t3_reload_hi, t3_reload_lo});
		t3_split <= 1'b1;
		cyc(2);
		chk("t3 split", 8'h02, {6'h00, t3_reload_hi, t3_reload_lo});
		// Forced interrupt stalls the clock
		op(1'b1, 2'h1, 8'h01);
		op(1'b0, 2'h1, 8'h00);
		chk("ctrl forced", 8'h01, got);
		cyc(8);
		chk("stall", 8'h00, {6'h00, t3_reload_hi, scl_oe_n});
		// Low-timeout handler: disabling the interface lets go of the clock line
		op(1'b1, 2'h0, cfg_m & 8'h7F);
		cyc(2);
		chk("timeout release", 8'h01, {7'h00, scl_oe_n});
		op(1'b1, 2'h1, 8'h00);
		op(1'b0, 2'h1, 8'h00);
		chk("ctrl cleared", 8'h00, got);
		op(1'b1, 2'h0, cfg_m);
		t3_split <= 1'b0;
		// Master START, two bytes, STOP plus START between them
		op(1'b1, 2'h1, 8'h20);
		wait_bit(2'h1, 0, 1'b1);
		chk("start status", 8'hA1, got & 8'hA1);
		op(1'b0, 2'h0, 8'h00);
		chk("busy", 8'h20, got & 8'h20);
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			d = seed[7:0];
			exp_q.push_back(d);
			op(1'b1, 2'h3, d);
			op(1'b1, 2'h1, 8'h00);
			wait_bit(2'h1, 0, 1'b1);
			chk("byte status", 8'hC3, got);
			chk("wire byte", exp_q.pop_front(), rx_byte);
			if (i == 0) begin
				op(1'b1, 2'h1, 8'h30);
				wait_bit(2'h1, 0, 1'b1);
				chk("restart", 8'hA1, got & 8'hA1);
			end
		end
		op(1'b1, 2'h1, 8'h10);
		wait_bit(2'h1, 7, 1'b0);
		chk("after stop", 8'h00, got & 8'hB1);
		wait_bit(2'h0, 5, 1'b0);
		cyc(1);
		tally_and_finish();
	end
	// Watchdog well beyond the expected run
	initial begin
		#400000;
		miscompares++;
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
